/* core/pfwe_cfg.svh */
`ifndef PFWE_CFG_SVH
`define PFWE_CFG_SVH

// fixed byte values
`define PFWE_IDLE_BYTE      8'hff
`define PFWE_COMMA_BYTE     8'hbc
`define PFWE_HOLD_ON_BYTE   8'hf1
`define PFWE_HOLD_OFF_BYTE  8'hf0
`define PFWE_K285_RDN       10'h0fa
`define PFWE_K285_RDP       10'h305

// word prefixes
`define PFWE_PFX_HEADER     4'ha
`define PFWE_PFX_TRAILER    4'hb
`define PFWE_PFX_EMPTY      4'he
`define PFWE_PFX_REGION     3'h6
`define PFWE_PFX_SHORT      2'h1
`define PFWE_PFX_LONG       2'h0

// word lengths in bytes
`define PFWE_LEN1           2'h1
`define PFWE_LEN2           2'h2
`define PFWE_LEN3           2'h3

// mode selector codes
`define PFWE_MODE_CONFIG    2'h0
`define PFWE_MODE_TRIG      2'h1
`define PFWE_MODE_CONT      2'h2

// counters and depths
`define PFWE_XCNT_W         9
`define PFWE_XCNT_LO        3
`define PFWE_XCNT_HI        8
`define PFWE_EXPCNT_W       2
`define PFWE_START_Q_DEPTH  5'h10
`define PFWE_OUT_FIFO_DEPTH 16
`define PFWE_OUT_FIFO_W     26

// crossing-rate timing
`define PFWE_CLK_MHZ        100
`define PFWE_XING_MHZ       40
`define PFWE_ACC_W          7

`endif

/* core/pfwe_pkg.sv */
package pfwe_pkg;

   typedef enum logic [2:0] {
      PFWE_ITEM_OPEN    = 3'h0,
      PFWE_ITEM_REGION  = 3'h1,
      PFWE_ITEM_SHORT   = 3'h2,
      PFWE_ITEM_CLUSTER = 3'h3,
      PFWE_ITEM_CLOSE   = 3'h4
   } pfwe_item_e;

   typedef enum logic [1:0] {
      PFWE_SRC_WORD  = 2'h0,
      PFWE_SRC_HOLD  = 2'h1,
      PFWE_SRC_COMMA = 2'h2,
      PFWE_SRC_NONE  = 2'h3
   } pfwe_src_e;

endpackage : pfwe_pkg

/* core/pfwe_top.sv */
// Summary of operation
// R1 - comma is K28.5, disparity chosen, serial only
// R2 - fill stream with commas when nothing ready
// R3 - single drop: pad words to three bytes
// R4 - frame header: 1010, position id, start data
// R5 - start data: crossing bits 8:3, exposure bits 1:0
// R6 - crossing counter at 40 MHz, command clears it
// R7 - trailer: 1011, four flags, idle byte
// R8 - triggered hold violation: flags are 1,000
// R9 - otherwise flags 0, discard, overflow, hold-changed
// R10 - continuous: trigger into full start queue
// R11 - continuous: slice dropped sets discard flag
// R12 - continuous: hold rises during readout sets flag
// R13 - no hits: single 24-bit empty-frame word
// R14 - region header 110 plus index, ascending
// R15 - short hit: 01, encoder index, address
// R16 - cluster: 00, index and address, 0, map
// R17 - map bit 0 is next pixel, bit 6 seventh
// R18 - hold codewords f1 on, f0 off, both buses
// R19 - bytes go out most significant first
// R20 - fillers never split a multi-byte word
// R21 - hold codeword at earliest word boundary
// R22 - 8b/10b, lsb first, thirty bits per load
// R23 - mode 0 config, 1 triggered, 2 continuous
// R24 - flags gathered per frame, cleared after trailer
`include "pfwe_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pfwe_fifo #(
   parameter int W = 26,
   parameter int D = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic          push;
   logic          pop;

   assign in_ready  = (count != D[AW:0]);
   assign out_valid = (count != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : pfwe_fifo

module pfwe_top #(
   parameter int FIFO_DEPTH = `PFWE_OUT_FIFO_DEPTH
) (
   input  wire logic        MCLK_IN,
   input  wire logic        RST_N_IN,
   input  wire logic [1:0]  MODE_IN,
   input  wire logic        SINGLE_DROP_MODE_IN,
   input  wire logic        CLUSTER_EN_IN,
   input  wire logic [3:0]  POSITION_ID_IN,
   input  wire logic        CROSSING_COUNT_CLEAR_CMD_IN,
   input  wire logic        EXPOSURE_PULSE_IN,
   input  wire logic        TRIGGER_IN,
   input  wire logic        HOLD_IN,
   input  wire logic [4:0]  START_QUEUE_LEVEL_IN,
   input  wire logic        SLICE_DISCARD_IN,
   input  wire logic        ITEM_VALID_IN,
   output logic             ITEM_READY_OUT,
   input  wire logic [2:0]  ITEM_KIND_IN,
   input  wire logic [4:0]  ITEM_REGION_IN,
   input  wire logic [3:0]  ITEM_ENCODER_IN,
   input  wire logic [9:0]  ITEM_ADDR_IN,
   input  wire logic [6:0]  ITEM_MAP_IN,
   output logic [29:0]      SER_WORD_OUT,
   output logic             SER_VALID_OUT,
   input  wire logic        SER_TAKE_IN,
   output logic [7:0]       LBUS_DATA_OUT,
   output logic             LBUS_STROBE_OUT
);

   // codes for negative disparity, bit a in the msb
   localparam logic [5:0] enc6_tab [32] = '{
      6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38, 6'h39, 6'h25, 6'h15,
      6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a,
      6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   localparam logic [3:0] enc4_tab [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

   // 8b/10b, code returned as abcdei_fghj with a in bit 9
   function automatic logic [10:0] enc8b10b(input logic [7:0] b, input logic k,
                                            input logic rd);
      logic [5:0] c6;
      logic [3:0] c4;
      logic       r;
      r  = rd;
      c6 = enc6_tab[b[4:0]];
      if (r && (($countones(c6) != 3) || (b[4:0] == 5'h07))) begin
         c6 = ~c6;
      end
      if ($countones(c6) != 3) begin
         r = ~r;
      end
      c4 = enc4_tab[b[7:5]];
      // alternate x.7 avoids a run of five equal bits
      if ((b[7:5] == 3'h7) &&
          ((!r && ((b[4:0] == 5'h11) || (b[4:0] == 5'h12) || (b[4:0] == 5'h14))) ||
           (r && ((b[4:0] == 5'h0b) || (b[4:0] == 5'h0d) || (b[4:0] == 5'h0e))))) begin
         c4 = 4'b0111;
      end
      if (r && (($countones(c4) != 2) || (b[7:5] == 3'h3))) begin
         c4 = ~c4;
      end
      if ($countones(c4) != 2) begin
         r = ~r;
      end
      if (k) begin
         // only control symbol used is the comma
         return rd ? {1'b0, `PFWE_K285_RDP} : {1'b1, `PFWE_K285_RDN}; // [R1]
      end
      return {r, c6, c4};
   endfunction : enc8b10b

   function automatic logic [9:0] bit_rev10(input logic [9:0] c);
      logic [9:0] o;
      o = '0;
      for (int i = 0; i < 10; i++) begin
         o[i] = c[9 - i];
      end
      return o;
   endfunction : bit_rev10

   // crossing and exposure counters
   logic [`PFWE_ACC_W-1:0]    xing_acc;
   logic [`PFWE_ACC_W-1:0]    next_xing_acc;
   logic                      xing_tick;
   logic [`PFWE_XCNT_W-1:0]   xing_cnt;
   logic [`PFWE_EXPCNT_W-1:0] exp_cnt;

   assign next_xing_acc = xing_acc + `PFWE_ACC_W'(`PFWE_XING_MHZ);
   assign xing_tick     = (next_xing_acc >= `PFWE_ACC_W'(`PFWE_CLK_MHZ));

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         xing_acc <= '0;
         xing_cnt <= '0;
      end else begin
         // phase accumulator gives 40 MHz ticks from the 100 MHz clock
         xing_acc <= xing_tick ? next_xing_acc - `PFWE_ACC_W'(`PFWE_CLK_MHZ)
                               : next_xing_acc;
         if (CROSSING_COUNT_CLEAR_CMD_IN) begin
            xing_cnt <= '0; // [R6]
         end else if (xing_tick) begin
            xing_cnt <= xing_cnt + 1'b1; // [R6]
         end
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         exp_cnt <= '0;
      end else if (EXPOSURE_PULSE_IN) begin
         exp_cnt <= exp_cnt + 1'b1;
      end
   end

   // frame-level word builder
   logic        frame_open;
   logic        hdr_sent;
   logic [7:0]  start_data;
   logic        hold_seen;
   logic        f_viol;
   logic        f_discard;
   logic        f_overflow;
   logic        f_hold_chg;
   logic        fifo_in_ready;
   logic        push;
   logic [1:0]  push_len;
   logic [23:0] push_data;
   logic [25:0] push_word;
   logic        item_take;
   logic        need_hdr;
   logic        close_take;
   logic [3:0]  trl_flags;
   logic        mode_trig;
   logic        mode_cont;

   assign mode_trig = (MODE_IN == `PFWE_MODE_TRIG); // [R23]
   assign mode_cont = (MODE_IN == `PFWE_MODE_CONT); // [R23]
   assign need_hdr  = frame_open && !hdr_sent &&
                      (ITEM_KIND_IN != pfwe_pkg::PFWE_ITEM_CLOSE) &&
                      (ITEM_KIND_IN != pfwe_pkg::PFWE_ITEM_OPEN);
   assign ITEM_READY_OUT = fifo_in_ready && !need_hdr;
   assign item_take  = ITEM_VALID_IN && ITEM_READY_OUT;
   assign close_take = item_take && (ITEM_KIND_IN == pfwe_pkg::PFWE_ITEM_CLOSE);

   always_comb begin
      if (mode_trig && f_viol) begin
         trl_flags = {1'b1, 3'b000}; // [R8]
      end else begin
         trl_flags = {1'b0, f_discard, f_overflow, f_hold_chg}; // [R9]
      end
   end

   always_comb begin
      push      = 1'b0;
      push_len  = `PFWE_LEN1;
      push_data = '0;
      if (ITEM_VALID_IN && fifo_in_ready) begin
         if (need_hdr) begin
            push      = 1'b1;
            push_len  = `PFWE_LEN2;
            push_data = {`PFWE_PFX_HEADER, POSITION_ID_IN, start_data, 8'h00}; // [R4]
         end else begin
            unique case (ITEM_KIND_IN)
               pfwe_pkg::PFWE_ITEM_REGION: begin
                  push      = 1'b1;
                  push_data = {`PFWE_PFX_REGION, ITEM_REGION_IN, 16'h0000}; // [R14]
               end
               pfwe_pkg::PFWE_ITEM_SHORT: begin
                  push      = 1'b1;
                  push_len  = `PFWE_LEN2;
                  push_data = {`PFWE_PFX_SHORT, ITEM_ENCODER_IN, ITEM_ADDR_IN, 8'h00}; // [R15]
               end
               pfwe_pkg::PFWE_ITEM_CLUSTER: begin
                  push = 1'b1;
                  if (CLUSTER_EN_IN) begin
                     push_len  = `PFWE_LEN3;
                     push_data = {`PFWE_PFX_LONG, ITEM_ENCODER_IN, ITEM_ADDR_IN,
                                  1'b0, ITEM_MAP_IN}; // [R16] [R17]
                  end else begin
                     // clustering off: sent as short word
                     push_len  = `PFWE_LEN2;
                     push_data = {`PFWE_PFX_SHORT, ITEM_ENCODER_IN, ITEM_ADDR_IN, 8'h00}; // [R15]
                  end
               end
               pfwe_pkg::PFWE_ITEM_CLOSE: begin
                  push = frame_open;
                  if (hdr_sent) begin
                     push_len  = `PFWE_LEN2;
                     push_data = {`PFWE_PFX_TRAILER, trl_flags, `PFWE_IDLE_BYTE, 8'h00}; // [R7]
                  end else begin
                     push_len  = `PFWE_LEN3;
                     push_data = {`PFWE_PFX_EMPTY, POSITION_ID_IN, start_data,
                                  `PFWE_IDLE_BYTE}; // [R13]
                  end
               end
               default: begin
                  push = 1'b0;
               end
            endcase
         end
      end
   end

   always_comb begin
      push_word = {push_len, push_data};
      if (SINGLE_DROP_MODE_IN && (push_len == `PFWE_LEN1)) begin
         push_word = {`PFWE_LEN3, push_data[23:16], `PFWE_IDLE_BYTE, `PFWE_IDLE_BYTE}; // [R3]
      end else if (SINGLE_DROP_MODE_IN && (push_len == `PFWE_LEN2)) begin
         push_word = {`PFWE_LEN3, push_data[23:8], `PFWE_IDLE_BYTE}; // [R3]
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         frame_open <= 1'b0;
         hdr_sent   <= 1'b0;
         start_data <= '0;
      end else begin
         if (need_hdr && ITEM_VALID_IN && fifo_in_ready) begin
            hdr_sent <= 1'b1;
         end
         if (item_take && (ITEM_KIND_IN == pfwe_pkg::PFWE_ITEM_OPEN)) begin
            frame_open <= 1'b1;
            hdr_sent   <= 1'b0;
            start_data <= {xing_cnt[`PFWE_XCNT_HI:`PFWE_XCNT_LO], exp_cnt}; // [R5]
         end else if (close_take) begin
            frame_open <= 1'b0;
            hdr_sent   <= 1'b0;
         end
      end
   end

   // readout flags; a new event beats the end-of-frame clear
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         hold_seen  <= 1'b0;
         f_viol     <= 1'b0;
         f_discard  <= 1'b0;
         f_overflow <= 1'b0;
         f_hold_chg <= 1'b0;
      end else begin
         hold_seen  <= HOLD_IN;
         f_viol     <= (f_viol && !close_take) ||
                       (mode_trig && TRIGGER_IN && HOLD_IN); // [R8] [R24]
         f_overflow <= (f_overflow && !close_take) ||
                       (mode_cont && TRIGGER_IN &&
                        (START_QUEUE_LEVEL_IN >= `PFWE_START_Q_DEPTH)); // [R10] [R24]
         f_discard  <= (f_discard && !close_take) ||
                       (mode_cont && SLICE_DISCARD_IN); // [R11] [R24]
         f_hold_chg <= (f_hold_chg && !close_take) ||
                       (mode_cont && frame_open && HOLD_IN && !hold_seen); // [R12] [R24]
      end
   end

   // word buffer
   logic        fifo_out_valid;
   logic        fifo_pop;
   logic [25:0] fifo_out_data;

   pfwe_fifo #(
      .W (`PFWE_OUT_FIFO_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk       (MCLK_IN),
      .rst_n     (RST_N_IN),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // byte picker and three-character assembly
   logic [15:0] rest;
   logic [1:0]  rest_cnt;
   logic        hold_sent;
   logic [7:0]  asm_b [3];
   logic [2:0]  asm_k;
   logic [1:0]  asm_cnt;
   logic        ser_full;
   logic        asm_move;
   logic        gen;
   pfwe_pkg::pfwe_src_e src;
   logic [7:0]  gen_byte;
   logic        gen_k;
   logic        rd;
   logic [10:0] e0;
   logic [10:0] e1;
   logic [10:0] e2;

   assign gen = (asm_cnt != 2'h3);

   always_comb begin
      src      = pfwe_pkg::PFWE_SRC_NONE;
      gen_byte = `PFWE_COMMA_BYTE;
      gen_k    = 1'b0;
      if (gen) begin
         if (rest_cnt != 2'h0) begin
            src      = pfwe_pkg::PFWE_SRC_WORD; // [R20]
            gen_byte = rest[15:8];
         end else if (HOLD_IN != hold_sent) begin
            src      = pfwe_pkg::PFWE_SRC_HOLD; // [R21]
            gen_byte = HOLD_IN ? `PFWE_HOLD_ON_BYTE : `PFWE_HOLD_OFF_BYTE; // [R18]
         end else if (fifo_out_valid) begin
            src      = pfwe_pkg::PFWE_SRC_WORD;
            gen_byte = fifo_out_data[23:16]; // [R19]
         end else if (!ser_full) begin
            src      = pfwe_pkg::PFWE_SRC_COMMA; // [R2]
            gen_k    = 1'b1; // [R1]
         end
      end
   end

   assign fifo_pop = (src == pfwe_pkg::PFWE_SRC_WORD) && (rest_cnt == 2'h0);
   assign asm_move = (asm_cnt == 2'h3) && (!ser_full || SER_TAKE_IN);

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         rest     <= '0;
         rest_cnt <= '0;
      end else if (fifo_pop) begin
         rest     <= fifo_out_data[15:0]; // [R19]
         rest_cnt <= fifo_out_data[25:24] - 2'h1;
      end else if (src == pfwe_pkg::PFWE_SRC_WORD) begin
         rest     <= {rest[7:0], 8'h00};
         rest_cnt <= rest_cnt - 2'h1;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         hold_sent       <= 1'b0;
         LBUS_DATA_OUT   <= '0;
         LBUS_STROBE_OUT <= 1'b0;
      end else begin
         LBUS_STROBE_OUT <= (src == pfwe_pkg::PFWE_SRC_HOLD); // [R18]
         if (src == pfwe_pkg::PFWE_SRC_HOLD) begin
            hold_sent     <= HOLD_IN;
            LBUS_DATA_OUT <= gen_byte; // [R18]
         end
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         asm_cnt <= '0;
         asm_k   <= '0;
         for (int i = 0; i < 3; i++) begin
            asm_b[i] <= '0;
         end
      end else if (asm_move) begin
         asm_cnt <= '0;
      end else if (src != pfwe_pkg::PFWE_SRC_NONE) begin
         asm_b[asm_cnt] <= gen_byte;
         asm_k[asm_cnt] <= gen_k;
         asm_cnt        <= asm_cnt + 2'h1;
      end
   end

   // disparity chains through a load
   assign e0 = enc8b10b(asm_b[0], asm_k[0], rd);
   assign e1 = enc8b10b(asm_b[1], asm_k[1], e0[10]);
   assign e2 = enc8b10b(asm_b[2], asm_k[2], e1[10]);

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         rd           <= 1'b0;
         ser_full     <= 1'b0;
         SER_WORD_OUT <= '0;
      end else if (asm_move) begin
         rd           <= e2[10];
         ser_full     <= 1'b1;
         // bit 0 leaves first: first character, its bit a
         SER_WORD_OUT <= {bit_rev10(e2[9:0]), bit_rev10(e1[9:0]),
                          bit_rev10(e0[9:0])}; // [R22]
      end else if (SER_TAKE_IN) begin
         ser_full <= 1'b0;
      end
   end

   assign SER_VALID_OUT = ser_full;

endmodule : pfwe_top

`default_nettype wire

/* dv/pfwe_ru_model.sv */
`include "pfwe_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pfwe_ru_model (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [29:0] word_in,
   input  wire logic        valid_in,
   input  wire logic        stall_in,
   output logic             take_out
);
   localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
      6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
   logic [7:0] rx[$];
   int         commas = 0;
   int         bad = 0;
   logic       rd;
   // {disparity after, abcdeifghj}
   function automatic logic [10:0] enc(input logic [7:0] b, input logic r);
      logic [5:0] s;
      logic [3:0] f;
      s = T6[b[4:0]];
      if (r && ($countones(s) != 3 || b[4:0] == 5'h07)) s = ~s;
      if ($countones(s) != 3) r = ~r;
      f = T4[b[7:5]];
      if (b[7:5] == 3'h7 && ((!r && b[4:0] inside {17, 18, 20}) ||
          (r && b[4:0] inside {11, 13, 14}))) f = 4'h7;
      if (r && ($countones(f) != 2 || b[7:5] == 3'h3)) f = ~f;
      if ($countones(f) != 2) r = ~r;
      return {r, s, f};
   endfunction : enc
   always @(posedge clk_in) begin
      logic [9:0]  c;
      logic [10:0] e;
      logic        hit;
      if (!rst_n_in) begin
         rd = 1'b0;
      end else if (valid_in && take_out) begin
         for (int i = 0; i < 3; i++) begin
            c = {<<{word_in[10*i +: 10]}};
            hit = 1'b0;
            if (c == (rd ? `PFWE_K285_RDP : `PFWE_K285_RDN)) begin
               commas++;
               rd = ~rd;
               hit = 1'b1;
            end
            for (int b = 0; b < 256 && !hit; b++) begin
               e = enc(8'(b), rd);
               if (e[9:0] == c) begin
                  rx.push_back(8'(b));
                  rd = e[10];
                  hit = 1'b1;
               end
            end
            if (!hit) bad++;
         end
      end
      take_out <= #1 !stall_in;
   end
endmodule : pfwe_ru_model
`default_nettype wire

/* dv/pfwe_top_monitor.sv */
`include "pfwe_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pfwe_top_monitor (
   input wire logic        MCLK_IN,
   input wire logic        RST_N_IN,
   input wire logic        ITEM_VALID_IN,
   input wire logic        ITEM_READY_OUT,
   input wire logic [2:0]  ITEM_KIND_IN,
   input wire logic        HOLD_IN,
   input wire logic [29:0] SER_WORD_OUT,
   input wire logic        SER_VALID_OUT,
   input wire logic        SER_TAKE_IN,
   input wire logic [7:0]  LBUS_DATA_OUT,
   input wire logic        LBUS_STROBE_OUT
);
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   logic on_sent;
   // first codeword after reset is hold on
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         on_sent <= 1'b0;
      end else if (LBUS_STROBE_OUT) begin
         on_sent <= (LBUS_DATA_OUT == `PFWE_HOLD_ON_BYTE);
      end
   end
   load_stands_a: assert property (
      SER_VALID_OUT && !SER_TAKE_IN |=> SER_VALID_OUT && $stable(SER_WORD_OUT))
      else $error("serial load moved untaken");
   comma_refill_a: assert property (
      SER_VALID_OUT && SER_TAKE_IN |-> ##[1:8] SER_VALID_OUT)
      else $error("no reload after take");
   start_fill_a: assert property (
      $rose(RST_N_IN) |-> ##[1:10] SER_VALID_OUT)
      else $error("no load after reset");
   strobe_pulse_a: assert property (
      LBUS_STROBE_OUT |=> !LBUS_STROBE_OUT)
      else $error("strobe too long");
   code_alternates_a: assert property (
      LBUS_STROBE_OUT |-> LBUS_DATA_OUT == (on_sent ? `PFWE_HOLD_OFF_BYTE : `PFWE_HOLD_ON_BYTE))
      else $error("codeword out of order");
   hold_on_level_a: assert property (
      LBUS_STROBE_OUT && LBUS_DATA_OUT == `PFWE_HOLD_ON_BYTE
      |-> $past(HOLD_IN) || $past(HOLD_IN, 2) || $past(HOLD_IN, 3))
      else $error("on code without hold");
   hold_off_level_a: assert property (
      LBUS_STROBE_OUT && LBUS_DATA_OUT == `PFWE_HOLD_OFF_BYTE
      |-> !$past(HOLD_IN) || !$past(HOLD_IN, 2) || !$past(HOLD_IN, 3))
      else $error("off code with hold");
   header_gap_a: assert property (
      ITEM_VALID_IN && ITEM_READY_OUT && ITEM_KIND_IN == 3'h0 ##1
      ITEM_VALID_IN && ITEM_KIND_IN == 3'h1 |-> !ITEM_READY_OUT)
      else $error("no header slot");
   cover property (LBUS_STROBE_OUT && LBUS_DATA_OUT == `PFWE_HOLD_ON_BYTE);
   cover property ((ITEM_VALID_IN && !ITEM_READY_OUT) [*3]);
   cover property (SER_VALID_OUT && SER_TAKE_IN ##1 SER_VALID_OUT && SER_TAKE_IN);
endmodule : pfwe_top_monitor
bind pfwe_top pfwe_top_monitor u_pfwe_top_monitor (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
   .ITEM_VALID_IN(ITEM_VALID_IN), .ITEM_READY_OUT(ITEM_READY_OUT),
   .ITEM_KIND_IN(ITEM_KIND_IN), .HOLD_IN(HOLD_IN), .SER_WORD_OUT(SER_WORD_OUT),
   .SER_VALID_OUT(SER_VALID_OUT), .SER_TAKE_IN(SER_TAKE_IN),
   .LBUS_DATA_OUT(LBUS_DATA_OUT), .LBUS_STROBE_OUT(LBUS_STROBE_OUT));
`default_nettype wire

/* dv/pfwe_top_tb.sv */
`include "pfwe_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pfwe_top_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [1:0]  mode = 2'h0;
   logic        sd = 1'b0;
   logic        cl = 1'b1;
   logic [3:0]  pos = 4'h5;
   logic        xclr = 1'b0;
   logic        expo = 1'b0;
   logic        trig = 1'b0;
   logic        hold = 1'b0;
   logic [4:0]  qlvl = 5'h00;
   logic        disc = 1'b0;
   logic        iv = 1'b0;
   logic        ir;
   logic [2:0]  kind = 3'h0;
   logic [4:0]  rix = 5'h00;
   logic [3:0]  eix = 4'h0;
   logic [9:0]  addr = 10'h000;
   logic [6:0]  map = 7'h00;
   logic [29:0] sw;
   logic        sv;
   logic        take;
   logic        stall = 1'b0;
   logic [7:0]  exp_q[$];
   int          fail_count = 0;
   int          compares = 0;
   int          cycles = 0;
   int          full_seen = 0;
   always #5 clk = ~clk;
   pfwe_top u_pfwe_top (.MCLK_IN(clk), .RST_N_IN(rst_n), .MODE_IN(mode),
      .SINGLE_DROP_MODE_IN(sd), .CLUSTER_EN_IN(cl), .POSITION_ID_IN(pos),
      .CROSSING_COUNT_CLEAR_CMD_IN(xclr), .EXPOSURE_PULSE_IN(expo), .TRIGGER_IN(trig),
      .HOLD_IN(hold), .START_QUEUE_LEVEL_IN(qlvl), .SLICE_DISCARD_IN(disc),
      .ITEM_VALID_IN(iv), .ITEM_READY_OUT(ir), .ITEM_KIND_IN(kind), .ITEM_REGION_IN(rix),
      .ITEM_ENCODER_IN(eix), .ITEM_ADDR_IN(addr), .ITEM_MAP_IN(map), .SER_WORD_OUT(sw),
      .SER_VALID_OUT(sv), .SER_TAKE_IN(take), .LBUS_DATA_OUT(), .LBUS_STROBE_OUT());
   pfwe_ru_model u_pfwe_ru_model (.clk_in(clk), .rst_n_in(rst_n), .word_in(sw),
      .valid_in(sv), .stall_in(stall), .take_out(take));
   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      compares++;
      if (seen !== expd) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask : check
   task automatic finish_test;
      $display("fail_count %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask : pulse
   task automatic item(input logic [2:0] k, input logic [3:0] e, input logic [9:0] a,
                       input logic [6:0] m, input logic [4:0] r);
      int n = 0;
      kind = k;
      eix = e;
      addr = a;
      map = m;
      rix = r;
      iv = 1'b1;
      #1;
      while (ir !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      if (n > 1) full_seen++;
      tick(1);
   endtask : item
   task automatic put(input logic [23:0] v, input int n);
      for (int k = n - 1; k >= 0; k--) exp_q.push_back(v[8*k +: 8]);
      for (int k = n; k < 3 && sd; k++) exp_q.push_back(`PFWE_IDLE_BYTE);
   endtask : put
   task automatic frame(input int nreg, input int nhit, input logic [3:0] fl,
                        input logic [7:0] fsd, input logic hm);
      logic [3:0] e;
      logic [9:0] a;
      logic [6:0] m;
      item(3'h0, 4'h0, 10'h000, 7'h00, 5'h00);
      if (hm) begin
         iv = 1'b0;
         hold = 1'b1;
         exp_q.push_back(`PFWE_HOLD_ON_BYTE);
         tick(10);
      end
      if (nreg == 0) put({`PFWE_PFX_EMPTY, pos, fsd, 8'hff}, 3);
      else put({8'h00, `PFWE_PFX_HEADER, pos, fsd}, 2);
      for (int i = 0; i < nreg; i++) begin
         item(3'h1, 4'h0, 10'h000, 7'h00, 5'(3 * i + 1));
         put({16'h0000, 3'h6, 5'(3 * i + 1)}, 1);
         for (int j = 0; j < nhit; j++) begin
            e = 4'(i + j);
            a = 10'h3ff - 10'(37 * j);
            m = 7'h41 ^ 7'(j);
            item(j[0] ? 3'h3 : 3'h2, e, a, m, 5'h00);
            if (j[0] && cl) put({2'h0, e, a, 1'b0, m}, 3);
            else put({8'h00, 2'h1, e, a}, 2);
         end
      end
      item(3'h4, 4'h0, 10'h000, 7'h00, 5'h00);
      iv = 1'b0;
      if (nreg > 0) put({8'h00, `PFWE_PFX_TRAILER, fl, 8'hff}, 2);
   endtask : frame
   task automatic drain;
      int n = 0;
      while (u_pfwe_ru_model.rx.size() < exp_q.size() && n < 3000) begin
         tick(1);
         n++;
      end
      tick(20);
      check(u_pfwe_ru_model.rx.size(), exp_q.size());
      foreach (exp_q[i]) check(u_pfwe_ru_model.rx[i], exp_q[i]);
      u_pfwe_ru_model.rx.delete();
      exp_q.delete();
   endtask : drain
   task automatic hold_step(input logic v, input logic tr);
      hold = v;
      exp_q.push_back(v ? `PFWE_HOLD_ON_BYTE : `PFWE_HOLD_OFF_BYTE);
      tick(5);
      if (tr) pulse(trig);
   endtask : hold_step
   initial begin
      tick(4);
      rst_n = 1'b1;
      tick(40);
      check(u_pfwe_ru_model.rx.size(), 0);
      check(u_pfwe_ru_model.commas > 0, 1);
      hold_step(1'b1, 1'b1);
      hold_step(1'b0, 1'b0);
      drain();
      mode = `PFWE_MODE_TRIG;
      repeat (3) pulse(expo);
      pulse(xclr);
      frame(2, 3, 4'h0, 8'h03, 1'b0);
      drain();
      hold_step(1'b1, 1'b1);
      hold_step(1'b0, 1'b0);
      pulse(xclr);
      tick(128);
      frame(1, 2, 4'h8, 8'h1b, 1'b0);
      drain();
      pulse(xclr);
      frame(0, 0, 4'h0, 8'h03, 1'b0);
      frame(1, 1, 4'h0, 8'h03, 1'b0);
      drain();
      mode = `PFWE_MODE_CONT;
      sd = 1'b1;
      cl = 1'b0;
      qlvl = 5'h10;
      pulse(trig);
      qlvl = 5'h00;
      pulse(disc);
      pulse(xclr);
      frame(2, 2, 4'h7, 8'h03, 1'b1);
      drain();
      hold_step(1'b0, 1'b0);
      drain();
      full_seen = 0;
      stall = 1'b1;
      fork
         begin
            tick(150);
            stall = 1'b0;
         end
      join_none
      pulse(xclr);
      frame(1, 30, 4'h0, 8'h03, 1'b0);
      drain();
      check(full_seen > 0, 1);
      check(u_pfwe_ru_model.bad, 0);
      finish_test();
   end
endmodule : pfwe_top_tb
`default_nettype wire
